// *** rtl/dpl_pkg.sv ***
// shared constants and types for the parallel input latch link
package dpl_pkg;
    localparam int DATA_W = 10;
    localparam int FIFO_DEPTH = 32;
    localparam logic [DATA_W-1:0] CODE_MAX = 10'h3ff;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MAX_RATE_MSPS = 210;
    // least sample period allowed by the converter, rounded up to whole nanoseconds, then to whole cycles
    localparam int MIN_SAMPLE_PERIOD_NS = (1000 + MAX_RATE_MSPS - 1) / MAX_RATE_MSPS;
    localparam int MIN_SAMPLE_CYCLES_RAW = (MIN_SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // each clock phase spans two cycles so the two-stage synchroniser sees it
    localparam int PHASE_CYCLES = 2;
    localparam logic [1:0] PHASE_LAST = 2'h1;
    localparam int SAMPLE_CYCLES = 2 * PHASE_CYCLES;

    typedef enum logic [1:0] {
        CLK_MODE_SINGLE,
        CLK_MODE_DIFF,
        CLK_MODE_PECL
    } dpl_clk_mode_t;
    localparam logic [1:0] STRAP_CLOCK_GROUND = 2'h0;
    localparam logic [1:0] STRAP_CLOCK_SUPPLY = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;
endpackage

// *** rtl/dpl_if.sv ***
// link between the data source and the converter front end
`timescale 1ns/100ps
interface dpl_if;
    logic [dpl_pkg::DATA_W-1:0] dataWord;
    logic clockPos;
    logic clockNeg;
    logic [1:0] clockInputSelect;
    modport source (output dataWord, output clockPos, output clockNeg, output clockInputSelect);
    modport device (input dataWord, input clockPos, input clockNeg, input clockInputSelect);
endinterface

// *** rtl/dpl_fifo.sv ***
// word fifo with valid/ready on both sides
`timescale 1ns/100ps
module dpl_fifo #(
    parameter int WIDTH = dpl_pkg::DATA_W,
    parameter int DEPTH = dpl_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    logic doWrite;
    logic doRead;

    assign inReady = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData = mem_q[rdPtr_q[AW-1:0]];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem_q[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
        end else if (doWrite) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdPtr_q <= '0;
        end else if (doRead) begin
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end
endmodule

// *** rtl/dpl_source.sv ***
// data source end: buffers words and drives code plus sampling clock
`timescale 1ns/100ps
module dpl_source (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wordValid,
    output logic wordReady,
    input wire logic [dpl_pkg::DATA_W-1:0] wordIn,
    input wire dpl_pkg::dpl_clk_mode_t modeSel,
    dpl_if.source link
);
    logic fifoValid;
    logic fifoPop;
    logic [dpl_pkg::DATA_W-1:0] fifoData;
    logic [1:0] phaseCnt_q;
    logic clk_q;
    logic [dpl_pkg::DATA_W-1:0] data_q;
    logic phaseEnd;
    logic negClk_q;
    logic [1:0] strap_q;

    dpl_fifo #(.WIDTH(dpl_pkg::DATA_W), .DEPTH(dpl_pkg::FIFO_DEPTH)) dpl_fifo_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(wordValid),
        .inReady(wordReady),
        .inData(wordIn),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    assign phaseEnd = phaseCnt_q == dpl_pkg::PHASE_LAST;
    // a word leaves the fifo only at a falling edge, so the fifo fills when the user outruns the link
    assign fifoPop = phaseEnd && clk_q && fifoValid;

    always_ff @(posedge clk) begin
        if (sys_rst || phaseEnd) begin
            phaseCnt_q <= '0;
        end else begin
            phaseCnt_q <= phaseCnt_q + 2'h1;
        end
    end

    // equal phases: 50% duty and a rate far under the converter limit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_q <= 1'b0;
        end else if (phaseEnd) begin
            clk_q <= ~clk_q;
        end
    end

    // empty fifo: last word is repeated rather than inventing a value
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_q <= '0;
        end else if (fifoPop) begin
            data_q <= fifoData;
        end
    end

    assign link.dataWord = data_q;
    // negative leg takes the inverse of the next value of the positive leg, so both legs move at the same edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            negClk_q <= modeSel != dpl_pkg::CLK_MODE_SINGLE;
        end else begin
            negClk_q <= (modeSel != dpl_pkg::CLK_MODE_SINGLE) && (phaseEnd ? clk_q : ~clk_q);
        end
    end

    always_ff @(posedge clk) begin
        unique case (modeSel)
            dpl_pkg::CLK_MODE_SINGLE: strap_q <= dpl_pkg::STRAP_CLOCK_GROUND;
            dpl_pkg::CLK_MODE_DIFF: strap_q <= dpl_pkg::STRAP_CLOCK_SUPPLY;
            default: strap_q <= dpl_pkg::STRAP_FLOAT;
        endcase
    end

    assign link.clockPos = clk_q;
    assign link.clockNeg = negClk_q;
    assign link.clockInputSelect = strap_q;
endmodule

// *** rtl/dpl_device.sv ***
// converter front end: synchronises link, latches code on rising sample edge
`timescale 1ns/100ps
module dpl_device (
    input wire logic clk,
    input wire logic sys_rst,
    dpl_if.device link,
    output logic [dpl_pkg::DATA_W-1:0] trueCode,
    output logic [dpl_pkg::DATA_W-1:0] complementCode,
    output logic codeValid,
    output logic sampleStrobe,
    output dpl_pkg::dpl_clk_mode_t clockMode
);
    logic [dpl_pkg::DATA_W-1:0] dataMeta_q;
    logic [dpl_pkg::DATA_W-1:0] dataSync_q;
    logic posMeta_q;
    logic posSync_q;
    logic negMeta_q;
    logic negSync_q;
    logic [1:0] selMeta_q;
    logic [1:0] selSync_q;
    logic clkPrev_q;
    logic clkLevel;
    logic rise;
    logic modeTaken_q;
    logic [dpl_pkg::DATA_W-1:0] trueCode_q;
    logic [dpl_pkg::DATA_W-1:0] complement_q;
    logic valid_q;
    logic strobe_q;
    dpl_pkg::dpl_clk_mode_t mode_q;

    function automatic dpl_pkg::dpl_clk_mode_t decodeStrap(input logic [1:0] s);
        unique case (s)
            dpl_pkg::STRAP_CLOCK_GROUND: decodeStrap = dpl_pkg::CLK_MODE_SINGLE;
            dpl_pkg::STRAP_CLOCK_SUPPLY: decodeStrap = dpl_pkg::CLK_MODE_DIFF;
            default: decodeStrap = dpl_pkg::CLK_MODE_PECL;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        dataMeta_q <= link.dataWord;
        dataSync_q <= dataMeta_q;
        posMeta_q <= link.clockPos;
        posSync_q <= posMeta_q;
        negMeta_q <= link.clockNeg;
        negSync_q <= negMeta_q;
        selMeta_q <= link.clockInputSelect;
        selSync_q <= selMeta_q;
    end

    // strap is caught once after reset release, not under reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeTaken_q <= 1'b0;
            mode_q <= dpl_pkg::CLK_MODE_SINGLE;
        end else if (!modeTaken_q) begin
            modeTaken_q <= 1'b1;
            mode_q <= decodeStrap(selSync_q);
        end
    end

    // single-ended ignores the negative pin; differential modes need both legs
    assign clkLevel = (mode_q == dpl_pkg::CLK_MODE_SINGLE) ? posSync_q : (posSync_q && !negSync_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkPrev_q <= 1'b0;
        end else begin
            clkPrev_q <= clkLevel;
        end
    end

    assign rise = clkLevel && !clkPrev_q && modeTaken_q;

    // the converter defines no reset code; trueCode, complementCode and codeValid read zero until the first captured word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trueCode_q <= '0;
        end else if (rise) begin
            trueCode_q <= dataSync_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            complement_q <= '0;
        end else if (rise) begin
            complement_q <= dpl_pkg::CODE_MAX - dataSync_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_q <= 1'b0;
        end else if (rise) begin
            valid_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= rise;
        end
    end

    assign trueCode = trueCode_q;
    assign complementCode = complement_q;
    assign codeValid = valid_q;
    assign sampleStrobe = strobe_q;
    assign clockMode = mode_q;
endmodule

// *** verif/dpl_link_checker.sv ***
// checker on the link pins and device outputs
`timescale 1ns/100ps
module dpl_link_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [9:0] dataWord,
    input wire logic clockPos,
    input wire logic clockNeg,
    input wire logic [1:0] clockInputSelect,
    input wire logic [9:0] trueCode,
    input wire logic [9:0] complementCode,
    input wire logic codeValid,
    input wire logic sampleStrobe,
    input wire dpl_pkg::dpl_clk_mode_t clockMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_DATA_AT_FALL: assert property ($changed(dataWord) |-> $fell(clockPos))
        else $error("data moved off falling edge");
    AST_CLK_SHAPE: assert property ($rose(clockPos) |=> clockPos ##1 !clockPos [*2] ##1 clockPos)
        else $error("sample clock shape wrong");
    // data is stable from one fall to the next, so three cycles back is safe
    AST_LATCH: assert property (sampleStrobe |-> codeValid && trueCode == $past(dataWord, 3))
        else $error("latched code differs from link");
    AST_HOLD: assert property ($changed(trueCode) && codeValid |-> ##[0:1] sampleStrobe)
        else $error("code moved without a strobe");
    AST_STROBE_ONE: assert property (sampleStrobe |=> !sampleStrobe [*3])
        else $error("strobe too long or too close");
    AST_COMPLEMENT: assert property (codeValid |-> complementCode == dpl_pkg::CODE_MAX - trueCode)
        else $error("complement not 1023 minus code");
    AST_INVALID_ZERO: assert property (!codeValid |-> trueCode == 10'h000 && complementCode == 10'h000)
        else $error("codes nonzero before valid");
    AST_NEG_LEG: assert property (
        clockInputSelect == dpl_pkg::STRAP_CLOCK_GROUND ? !clockNeg : clockNeg != clockPos)
        else $error("negative clock leg wrong");
    AST_MODE_MAP: assert property (
        codeValid |-> clockInputSelect == (clockMode == dpl_pkg::CLK_MODE_SINGLE
        ? dpl_pkg::STRAP_CLOCK_GROUND : clockMode == dpl_pkg::CLK_MODE_DIFF ? dpl_pkg::STRAP_CLOCK_SUPPLY
        : dpl_pkg::STRAP_FLOAT))
        else $error("strap and decoded mode disagree");
endmodule

// *** verif/dac_parallel_input_latch_tb_top.sv ***
// bench joining source and device over the link
`timescale 1ns/100ps
module dac_parallel_input_latch_tb_top;
    logic clk = 0;
    logic sys_rst = 1;
    logic wordValid = 0;
    logic [9:0] wordIn = 10'h000;
    dpl_pkg::dpl_clk_mode_t modeSel = dpl_pkg::CLK_MODE_SINGLE;
    logic wordReady, codeValid, sampleStrobe;
    logic [9:0] trueCode, complementCode, expW;
    logic [9:0] lastSeen = 10'h000;
    dpl_pkg::dpl_clk_mode_t clockMode;
    int errors = 0, n_tests = 0, cycles = 0, refused = 0;
    logic [9:0] expQ[$];
    logic [9:0] codes[4] = '{10'h3ff, 10'h000, 10'h200, 10'h001};
    always #20 clk = ~clk;
    dpl_if linkIf();
    dpl_source dpl_source_inst (.clk(clk), .sys_rst(sys_rst), .wordValid(wordValid), .wordReady(wordReady),
        .wordIn(wordIn), .modeSel(modeSel), .link(linkIf.source));
    dpl_device dpl_device_inst (.clk(clk), .sys_rst(sys_rst), .link(linkIf.device), .trueCode(trueCode),
        .complementCode(complementCode), .codeValid(codeValid), .sampleStrobe(sampleStrobe),
        .clockMode(clockMode));
    dpl_link_checker dpl_link_checker_inst (.clk(clk), .sys_rst(sys_rst), .dataWord(linkIf.dataWord),
        .clockPos(linkIf.clockPos), .clockNeg(linkIf.clockNeg), .clockInputSelect(linkIf.clockInputSelect),
        .trueCode(trueCode), .complementCode(complementCode), .codeValid(codeValid),
        .sampleStrobe(sampleStrobe), .clockMode(clockMode));
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // refused words are simply not expected; wordReady is settled at the falling edge
    task automatic put(input logic [9:0] w);
        @(negedge clk);
        wordValid = 1;
        wordIn = w;
        if (wordReady === 1'b1) expQ.push_back(w);
        else refused++;
    endtask
    task automatic drain();
        @(negedge clk);
        wordValid = 0;
        for (int i = 0; i < 400 && expQ.size() > 0; i++) @(negedge clk);
        check("pending words", 10'h000, 10'(expQ.size()));
    endtask
    task automatic do_reset(input dpl_pkg::dpl_clk_mode_t m);
        @(negedge clk);
        modeSel = m;
        sys_rst = 1;
        repeat (10) @(negedge clk);
        check("codeValid in reset", 10'h000, 10'(codeValid));
        sys_rst = 0;
        repeat (3) @(negedge clk);
        check("clockMode", 10'(m), 10'(clockMode));
        check("strap", 10'(m == dpl_pkg::CLK_MODE_SINGLE ? dpl_pkg::STRAP_CLOCK_GROUND
            : m == dpl_pkg::CLK_MODE_DIFF ? dpl_pkg::STRAP_CLOCK_SUPPLY : dpl_pkg::STRAP_FLOAT),
            10'(linkIf.clockInputSelect));
    endtask
    // repeats of the held word are skipped, so queued neighbours must differ;
    // only this process writes lastSeen, so a reset cannot race a strobe seen at the same edge
    always @(negedge clk) begin
        if (sampleStrobe === 1'b1 && expQ.size() > 0 && trueCode !== lastSeen) begin
            expW = expQ.pop_front();
            check("trueCode", expW, trueCode);
            check("complementCode", dpl_pkg::CODE_MAX - expW, complementCode);
            check("codeValid", 10'h001, 10'(codeValid));
        end
        if (sys_rst === 1'b1) lastSeen = 10'h000;
        else if (sampleStrobe === 1'b1) lastSeen = trueCode;
    end
    always @(negedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        for (int m = 0; m < 3; m++) begin
            do_reset(dpl_pkg::dpl_clk_mode_t'(m));
            foreach (codes[i]) put(codes[i]);
            drain();
        end
        for (int i = 0; i < 60; i++) put(10'(i + 16));
        check("fifo refused", 10'h001, 10'(refused > 0));
        drain();
        give_verdict();
    end
endmodule
